//--- rpsr_link_model.sv
/* downstream device on the link: level lines and PME messages.
   assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/10ps
`default_nettype none
module rpsr_link_model (
  // clock
  input wire logic mclk_in,
  // {link, presence, fatal, nonfatal, correctable}
  output var logic [4:0] lvl_out,
  // message strobe and requester id
  output var logic pme_out,
  output var logic [15:0] rid_out
);
  // ****************************************
  // drivers
  // ****************************************
  initial begin
    lvl_out = 5'h00;
    pme_out = 1'b0;
    rid_out = 16'h0000;
  end
  task lines(input logic [4:0] v);
    @(negedge mclk_in);
    lvl_out = v;
  endtask
  // id is only valid with the strobe; inverted after so stale ids show up
  task pme(input logic [15:0] r);
    @(negedge mclk_in);
    pme_out = 1'b1;
    rid_out = r;
    @(negedge mclk_in);
    pme_out = 1'b0;
    rid_out = ~r;
  endtask
endmodule
`default_nettype wire

//--- rpsr_map.vh
/*
 * Register map constants for the root port slot, root and power
 * management register block. Assumes byte offsets of configuration space;
 * the access port carries a dword-aligned address with byte enables.
 */
`ifndef RPSR_MAP_VH
`define RPSR_MAP_VH

// ****************************************
// dword addresses (byte offset >> 2)
// ****************************************
`define RPSR_DW_SLOT      6'h16
`define RPSR_DW_ROOTCTL   6'h17
`define RPSR_DW_ROOTSTS   6'h18
`define RPSR_DW_SUBSYSTEM_CAPABILITY_HEADER     6'h24
`define RPSR_DW_SUBSYSTEM_IDENTIFIER      6'h25
`define RPSR_DW_POWER_MGMT_CAPABILITY_HEADER     6'h28
`define RPSR_DW_POWER_MGMT_CONTROL_STATUS      6'h29

// ****************************************
// printed byte offsets
// ****************************************
`define RPSR_OFS_SLOT_STATUS   8'h5a
`define RPSR_OFS_ROOT_CONTROL  8'h5c
`define RPSR_OFS_ROOT_CAPS     8'h5e
`define RPSR_OFS_ROOT_STATUS   8'h60
`define RPSR_OFS_SUBSYSTEM_CAPABILITY_HEADER         8'h90
`define RPSR_OFS_SUBSYSTEM_IDENTIFIER          8'h94
`define RPSR_OFS_POWER_MGMT_CAPABILITY_HEADER         8'ha0
`define RPSR_OFS_PMC           8'ha2
`define RPSR_OFS_POWER_MGMT_CONTROL_STATUS          8'ha4

// ****************************************
// field positions
// ****************************************
`define RPSR_SL_LAC_BIT    8
`define RPSR_SL_PDS_BIT    6
`define RPSR_SL_PDC_BIT    3
`define RPSR_RC_PIE_BIT    3
`define RPSR_RC_SFE_BIT    2
`define RPSR_RC_SNE_BIT    1
`define RPSR_RC_SCE_BIT    0
`define RPSR_RS_PS_BIT     16
`define RPSR_PM_RCV_BIT    15
`define RPSR_PM_EN_BIT     8
// slot status sits in the upper half of its dword
`define RPSR_SL_LANE       16
// bit positions within the written dword, sized for the lane decode
`define RPSR_DW_LAC_POS    5'h18
`define RPSR_DW_PDC_POS    5'h13
`define RPSR_DW_PS_POS     5'h10

// ****************************************
// constant register values
// ****************************************
`define RPSR_ROOT_CAPS_VAL  16'h0000
`define RPSR_SUBSYSTEM_CAPABILITY_HEADER_VAL      16'ha00d
`define RPSR_POWER_MGMT_CAPABILITY_HEADER_VAL      16'h0001
`define RPSR_PMC_VAL        16'hc802
`define RPSR_PS_D0          2'b00
`define RPSR_PS_D3HOT       2'b11
`define RPSR_ZERO16         16'h0000
`define RPSR_ZERO32         32'h0000_0000

`endif

//--- rpsr_pme_queue.v
/*
 * Two-entry PME requester queue: one active entry, one pending entry.
 * Assumes pme message strobe and clear strobe are single cycle pulses on
 * the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rpsr_map.vh"

module rpsr_pme_queue (
  // clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // message input
  input wire pme_msg_in,
  input wire [15:0] pme_rid_in,
  // software clear of active flag
  input wire clear_in,
  // state
  output reg active_out,
  output reg [15:0] active_rid_out
);

  reg pend_reg;
  reg [15:0] pend_rid_reg;

  // ****************************************
  // queue
  // ****************************************
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      active_out <= 1'b0;
      active_rid_out <= `RPSR_ZERO16;
      pend_reg <= 1'b0;
      pend_rid_reg <= `RPSR_ZERO16;
    end else begin
      if (active_out && clear_in) begin
        // pending entry promotes; a same-cycle message takes the freed slot
        if (pend_reg) begin
          active_rid_out <= pend_rid_reg;
          pend_reg <= pme_msg_in;
          pend_rid_reg <= pme_rid_in;
        end else begin
          active_out <= pme_msg_in;
          if (pme_msg_in) begin
            active_rid_out <= pme_rid_in;
          end
        end
      end else if (pme_msg_in) begin
        if (!active_out) begin
          active_out <= 1'b1;
          active_rid_out <= pme_rid_in;
        end else if (!pend_reg) begin
          pend_reg <= 1'b1;
          pend_rid_reg <= pme_rid_in;
        end
        // both occupied: message dropped
      end
    end
  end

endmodule
`default_nettype wire

//--- rpsr_props.sv
/* assertions on the ports of rpsr_regs, bound to every instance of it.
   assumes one core clock and a synchronous active low reset. */
`timescale 1ns/10ps
`default_nettype none
module rpsr_props (
  // clock, reset, access port
  input wire logic mclk_in, rst_n_in, cfg_rd_in, cfg_rvalid_out,
  input wire logic [31:0] cfg_rdata_out,
  // event and gating inputs
  input wire logic fatal_err_in, nonfatal_err_in, correctable_err_in,
  input wire logic link_active_irq_en_in, mem_cycle_in,
  // outputs
  input wire logic pme_irq_out, hotplug_irq_out, system_error_out, cycle_accept_out,
  input wire logic [1:0] power_state_out
);
  // ****************************************
  // port properties
  // ****************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rvalid; cfg_rd_in |=> cfg_rvalid_out; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_no_rvalid; !cfg_rd_in |=> !cfg_rvalid_out; endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");
  // reset edges are excluded: they may load a fresh zero
  property p_hold; $past(rst_n_in) && !cfg_rvalid_out |-> $stable(cfg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_ps_legal; power_state_out != 2'b01 && power_state_out != 2'b10; endproperty
  a_ps_legal: assert property (p_ps_legal) else $error("illegal power state");
  property p_d3; power_state_out == 2'b11 [*3] |-> !cycle_accept_out; endproperty
  a_d3: assert property (p_d3) else $error("cycle passed in d3hot");
  property p_d0;
    power_state_out == 2'b00 ##1 mem_cycle_in && power_state_out == 2'b00
      ##1 power_state_out == 2'b00 |-> cycle_accept_out;
  endproperty
  a_d0: assert property (p_d0) else $error("cycle blocked in d0");
  property p_hp_off; !link_active_irq_en_in [*2] |-> !hotplug_irq_out; endproperty
  a_hp_off: assert property (p_hp_off) else $error("hot-plug irq while disabled");
  property p_serr_off;
    !(fatal_err_in || nonfatal_err_in || correctable_err_in) [*6] |-> !system_error_out;
  endproperty
  a_serr_off: assert property (p_serr_off) else $error("serr with no error");
  property p_rst;
    disable iff (1'b0) !rst_n_in |=> !(cfg_rvalid_out || pme_irq_out || hotplug_irq_out
      || system_error_out || cycle_accept_out) && power_state_out == 2'b00;
  endproperty
  a_rst: assert property (p_rst) else $error("output not cleared by reset");
  c_read: cover property (cfg_rvalid_out);
  c_hp: cover property (hotplug_irq_out);
  c_pme: cover property (pme_irq_out);
  c_serr: cover property (system_error_out);
endmodule
bind rpsr_regs rpsr_props u_props (.mclk_in, .rst_n_in, .cfg_rd_in, .cfg_rvalid_out,
  .cfg_rdata_out, .fatal_err_in, .nonfatal_err_in, .correctable_err_in,
  .link_active_irq_en_in, .mem_cycle_in, .pme_irq_out, .hotplug_irq_out,
  .system_error_out, .cycle_accept_out, .power_state_out);
`default_nettype wire

//--- rpsr_regs.v
/*
 * Slot status, root control/capabilities/status, subsystem vendor and
 * power management registers of a PCI Express root port.
 * Assumes a single-cycle configuration access port on the core clock and
 * link/error event inputs coming from pins or other clock domains.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rpsr_map.vh"

module rpsr_regs #(
  parameter [31:0] SUBSYS_ID_DEFAULT = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // configuration access port, dword address with byte enables
  input wire cfg_wr_in,
  input wire cfg_rd_in,
  input wire [5:0] cfg_dw_addr_in,
  input wire [3:0] cfg_be_in,
  input wire [31:0] cfg_wdata_in,
  output reg [31:0] cfg_rdata_out,
  output reg cfg_rvalid_out,
  // asynchronous status inputs
  input wire link_active_in,
  input wire presence_detect_in,
  input wire fatal_err_in,
  input wire nonfatal_err_in,
  input wire correctable_err_in,
  // same-domain inputs
  input wire slot_impl_flag_in,
  input wire link_active_irq_en_in,
  input wire [31:0] lpc_subsys_id_in,
  input wire pme_msg_in,
  input wire [15:0] pme_rid_in,
  // downstream cycle classes to gate in d3hot
  input wire io_cycle_in,
  input wire mem_cycle_in,
  input wire type1_cycle_in,
  // outputs
  output reg pme_irq_out,
  output reg hotplug_irq_out,
  output reg system_error_out,
  output reg cycle_accept_out,
  output reg [1:0] power_state_out
);

  // ****************************************
  // synchronisers
  // ****************************************
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg link_active_d_reg;
  reg presence_state_d_reg;

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {link_active_in, presence_detect_in, fatal_err_in,
                    nonfatal_err_in, correctable_err_in};
      sync2_reg <= sync1_reg;
    end
  end

  wire link_active_s = sync2_reg[4];
  wire fatal_s = sync2_reg[2];
  wire nonfatal_s = sync2_reg[1];
  wire correctable_s = sync2_reg[0];
  // no slot implemented: always reads as device present
  wire presence_state = slot_impl_flag_in ? sync2_reg[3] : 1'b1;

  // ****************************************
  // write decode helpers
  // ****************************************
  function wr_bit;
    input [3:0] be;
    input [31:0] data;
    input [4:0] pos;
    begin
      wr_bit = be[pos[4:3]] & data[pos];
    end
  endfunction

  wire wr_slot = cfg_wr_in && (cfg_dw_addr_in == `RPSR_DW_SLOT);
  wire wr_root_control = cfg_wr_in && (cfg_dw_addr_in == `RPSR_DW_ROOTCTL);
  wire wr_root_status = cfg_wr_in && (cfg_dw_addr_in == `RPSR_DW_ROOTSTS);
  wire wr_power_mgmt_control_status = cfg_wr_in && (cfg_dw_addr_in == `RPSR_DW_POWER_MGMT_CONTROL_STATUS);

  // slot status sits at 5Ah: upper half of the dword
  wire clr_lac = wr_slot && wr_bit(cfg_be_in, cfg_wdata_in, `RPSR_DW_LAC_POS);
  wire clr_pdc = wr_slot && wr_bit(cfg_be_in, cfg_wdata_in, `RPSR_DW_PDC_POS);
  wire clr_ps = wr_root_status &&
                wr_bit(cfg_be_in, cfg_wdata_in, `RPSR_DW_PS_POS);

  // ****************************************
  // state registers
  // ****************************************
  reg lac_reg;
  reg pdc_reg;
  reg [3:0] root_control_reg;
  reg pme_en_reg;
  reg [1:0] pstate_reg;
  reg pme_rcvd_reg;
  wire pme_active;
  wire [15:0] pme_rid_active;

  wire lac_set = link_active_s ^ link_active_d_reg;
  wire pdc_set = presence_state ^ presence_state_d_reg;

  rpsr_pme_queue u_pme_queue (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pme_msg_in(pme_msg_in),
    .pme_rid_in(pme_rid_in),
    .clear_in(clr_ps),
    .active_out(pme_active),
    .active_rid_out(pme_rid_active)
  );

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      link_active_d_reg <= 1'b0;
      // tracks presence_state in reset: 1 with no slot, 0 from the cleared synchronisers otherwise
      presence_state_d_reg <= presence_state;
      lac_reg <= 1'b0;
      pdc_reg <= 1'b0;
      root_control_reg <= 4'h0;
      pme_en_reg <= 1'b0;
      pstate_reg <= `RPSR_PS_D0;
      pme_rcvd_reg <= 1'b0;
    end else begin
      link_active_d_reg <= link_active_s;
      presence_state_d_reg <= presence_state;
      // set wins over a same-cycle clear
      lac_reg <= lac_set | (lac_reg & ~clr_lac);
      pdc_reg <= pdc_set | (pdc_reg & ~clr_pdc);
      if (wr_root_control && cfg_be_in[0]) begin
        root_control_reg <= cfg_wdata_in[3:0];
      end
      if (wr_power_mgmt_control_status && cfg_be_in[1]) begin
        pme_en_reg <= cfg_wdata_in[`RPSR_PM_EN_BIT];
      end
      if (wr_power_mgmt_control_status && cfg_be_in[0] &&
          (cfg_wdata_in[1:0] == `RPSR_PS_D0 ||
           cfg_wdata_in[1:0] == `RPSR_PS_D3HOT)) begin
        pstate_reg <= cfg_wdata_in[1:0];
      end
      // received indication is hardware status, follows queue occupancy
      pme_rcvd_reg <= pme_active;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  reg [31:0] rdata;

  always @* begin
    rdata = `RPSR_ZERO32;
    case (cfg_dw_addr_in)
      `RPSR_DW_SLOT: begin
        // mrl, power fault, attention bits left zero
        rdata[`RPSR_SL_LANE + `RPSR_SL_LAC_BIT] = lac_reg;
        rdata[`RPSR_SL_LANE + `RPSR_SL_PDS_BIT] = presence_state;
        rdata[`RPSR_SL_LANE + `RPSR_SL_PDC_BIT] = pdc_reg;
      end
      `RPSR_DW_ROOTCTL: begin
        rdata[15:0] = {12'h000, root_control_reg};
        rdata[31:16] = `RPSR_ROOT_CAPS_VAL;
      end
      `RPSR_DW_ROOTSTS: begin
        // pending bit 17 stays zero
        rdata[`RPSR_RS_PS_BIT] = pme_active;
        rdata[15:0] = pme_rid_active;
      end
      `RPSR_DW_SUBSYSTEM_CAPABILITY_HEADER: begin
        rdata[15:0] = `RPSR_SUBSYSTEM_CAPABILITY_HEADER_VAL;
      end
      `RPSR_DW_SUBSYSTEM_IDENTIFIER: begin
        rdata = lpc_subsys_id_in;
      end
      `RPSR_DW_POWER_MGMT_CAPABILITY_HEADER: begin
        rdata = {`RPSR_PMC_VAL, `RPSR_POWER_MGMT_CAPABILITY_HEADER_VAL};
      end
      `RPSR_DW_POWER_MGMT_CONTROL_STATUS: begin
        rdata[`RPSR_PM_RCV_BIT] = pme_rcvd_reg;
        rdata[`RPSR_PM_EN_BIT] = pme_en_reg;
        rdata[1:0] = pstate_reg;
      end
      default: begin
        rdata = `RPSR_ZERO32;
      end
    endcase
  end

  // ****************************************
  // outputs
  // ****************************************
  wire in_d3 = (pstate_reg == `RPSR_PS_D3HOT);

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out <= `RPSR_ZERO32;
      cfg_rvalid_out <= 1'b0;
      pme_irq_out <= 1'b0;
      hotplug_irq_out <= 1'b0;
      system_error_out <= 1'b0;
      cycle_accept_out <= 1'b0;
      power_state_out <= `RPSR_PS_D0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in) begin
        cfg_rdata_out <= rdata;
      end
      // level: holds while status and enable both set
      pme_irq_out <= pme_active & root_control_reg[`RPSR_RC_PIE_BIT];
      hotplug_irq_out <= lac_reg & link_active_irq_en_in;
      // forwarding ignores the command register enable
      system_error_out <= (fatal_s & root_control_reg[`RPSR_RC_SFE_BIT]) |
                          (nonfatal_s & root_control_reg[`RPSR_RC_SNE_BIT]) |
                          (correctable_s & root_control_reg[`RPSR_RC_SCE_BIT]);
      // own config accesses are never gated here
      cycle_accept_out <= (io_cycle_in | mem_cycle_in | type1_cycle_in) &
                          ~in_d3;
      power_state_out <= pstate_reg;
    end
  end

endmodule
`default_nettype wire

//--- rpsr_regs_test.sv
/* self-checking bench for rpsr_regs.
   assumes rpsr_link_model stands on the link side. */
`timescale 1ns/10ps
`default_nettype none
`include "rpsr_map.vh"
module rpsr_regs_test;
  logic mclk_in = 0, rst_n_in = 0, cfg_wr_in = 0, cfg_rd_in = 0, slot_impl = 0, link_active_irq_en = 0;
  logic mem = 0, io = 0, t1 = 0;
  logic [5:0] addr = 0;
  logic [3:0] be = 0;
  logic [31:0] wd = 0, lpc = 0, rd;
  logic [15:0] ra, rb;
  logic [1:0] ps, w;
  wire [31:0] cfg_rdata_out;
  wire cfg_rvalid_out, pme_irq_out, hotplug_irq_out, system_error_out, cycle_accept_out;
  wire [1:0] power_state_out;
  wire la, pd, fe, ne, ce, pm;
  wire [15:0] pme_requester_id;
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #2.5 mclk_in = ~mclk_in;
  rpsr_link_model link (.mclk_in, .lvl_out({la, pd, fe, ne, ce}), .pme_out(pm), .rid_out(pme_requester_id));
  rpsr_regs dut (.mclk_in, .rst_n_in, .cfg_wr_in, .cfg_rd_in, .cfg_dw_addr_in(addr),
    .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out, .cfg_rvalid_out,
    .link_active_in(la), .presence_detect_in(pd), .fatal_err_in(fe), .nonfatal_err_in(ne),
    .correctable_err_in(ce), .slot_impl_flag_in(slot_impl), .link_active_irq_en_in(link_active_irq_en),
    .lpc_subsys_id_in(lpc), .pme_msg_in(pm), .pme_rid_in(pme_requester_id), .io_cycle_in(io),
    .mem_cycle_in(mem), .type1_cycle_in(t1), .pme_irq_out, .hotplug_irq_out,
    .system_error_out, .cycle_accept_out, .power_state_out);
  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one-cycle strobe; read data is settled at the following falling edge
  task acc(input logic wr, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge mclk_in);
    cfg_wr_in = wr;
    cfg_rd_in = !wr;
    addr = a;
    be = b;
    wd = d;
    @(negedge mclk_in);
    cfg_wr_in = 0;
    cfg_rd_in = 0;
    rd = cfg_rdata_out;
  endtask
  task rdc(input logic [5:0] a, input logic [31:0] m, e);
    acc(0, a, 4'hf, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  function logic [1:0] exp_ps(input logic [1:0] cur, nw);
    return (nw == 2'b01 || nw == 2'b10) ? cur : nw;
  endfunction
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up;
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    ra = 16'($urandom(75960));
    lpc = $urandom;
    repeat (2) @(negedge mclk_in);
    rst_n_in = 1;
    rdc(`RPSR_DW_SLOT, 32'hffff_0000, 32'h0040_0000);
    rdc(`RPSR_DW_ROOTCTL, 32'hffff_ffff, 32'h0000_0000);
    rdc(`RPSR_DW_ROOTSTS, 32'hffff_ffff, 32'h0000_0000);
    acc(1, `RPSR_DW_SUBSYSTEM_CAPABILITY_HEADER, 4'hf, 32'hffff_ffff);
    rdc(`RPSR_DW_SUBSYSTEM_CAPABILITY_HEADER, 32'h0000_ffff, 32'h0000_a00d);
    rdc(`RPSR_DW_SUBSYSTEM_IDENTIFIER, 32'hffff_ffff, lpc);
    acc(1, `RPSR_DW_POWER_MGMT_CAPABILITY_HEADER, 4'hf, 32'hffff_ffff);
    rdc(`RPSR_DW_POWER_MGMT_CAPABILITY_HEADER, 32'hffff_ffff, 32'hc802_0001);
    acc(1, 6'h30, 4'hf, 32'hffff_ffff);
    rdc(6'h30, 32'hffff_ffff, 32'h0000_0000);
    rdc(`RPSR_DW_POWER_MGMT_CONTROL_STATUS, 32'hffff_ffff, 32'h0000_0000);
    acc(1, `RPSR_DW_POWER_MGMT_CONTROL_STATUS, 4'b0010, 32'h0000_0100);
    rdc(`RPSR_DW_POWER_MGMT_CONTROL_STATUS, 32'hffff_ffff, 32'h0000_0100);
    ps = 2'b00;
    for (int i = 0; i < 12; i++) begin
      w = i < 4 ? 2'(i) : 2'($urandom);
      acc(1, `RPSR_DW_POWER_MGMT_CONTROL_STATUS, 4'b0001, {30'h0, w});
      ps = exp_ps(ps, w);
      {io, mem, t1} = 3'($urandom);
      @(negedge mclk_in);
      chk(power_state_out, ps);
      chk(cycle_accept_out, (io | mem | t1) && ps != 2'b11);
    end
    acc(1, `RPSR_DW_POWER_MGMT_CONTROL_STATUS, 4'b0001, 32'h0000_0003);
    rdc(`RPSR_DW_POWER_MGMT_CONTROL_STATUS, 32'h0000_ffff, 32'h0000_0103);
    acc(1, `RPSR_DW_POWER_MGMT_CONTROL_STATUS, 4'b0001, 32'h0000_0000);
    slot_impl = 1;
    link_active_irq_en = 1;
    link.lines(5'b11000);
    repeat (6) @(negedge mclk_in);
    chk(hotplug_irq_out, 1);
    link_active_irq_en = 0;
    repeat (2) @(negedge mclk_in);
    chk(hotplug_irq_out, 0);
    link_active_irq_en = 1;
    rdc(`RPSR_DW_SLOT, 32'hffff_0000, 32'h0148_0000);
    acc(1, `RPSR_DW_SLOT, 4'b1100, 32'h0000_0000);
    rdc(`RPSR_DW_SLOT, 32'hffff_0000, 32'h0148_0000);
    acc(1, `RPSR_DW_SLOT, 4'b1100, 32'h0108_0000);
    rdc(`RPSR_DW_SLOT, 32'hffff_0000, 32'h0040_0000);
    chk(hotplug_irq_out, 0);
    link.lines(5'b10000);
    repeat (6) @(negedge mclk_in);
    rdc(`RPSR_DW_SLOT, 32'hffff_0000, 32'h0008_0000);
    for (int i = 0; i < 3; i++) begin
      acc(1, `RPSR_DW_ROOTCTL, 4'b0001, 32'(1 << i));
      link.lines(5'b10000 | 5'(1 << i));
      repeat (6) @(negedge mclk_in);
      chk(system_error_out, 1);
      link.lines(5'b10000 | 5'(1 << ((i + 1) % 3)));
      repeat (6) @(negedge mclk_in);
      chk(system_error_out, 0);
    end
    link.lines(5'b10000);
    rb = 16'($urandom);
    link.pme(ra);
    link.pme(rb);
    link.pme(~ra);
    repeat (3) @(negedge mclk_in);
    chk(pme_irq_out, 0);
    acc(1, `RPSR_DW_ROOTCTL, 4'b0001, 32'h0000_0008);
    @(negedge mclk_in);
    chk(pme_irq_out, 1);
    rdc(`RPSR_DW_ROOTSTS, 32'hffff_ffff, {15'h0, 1'b1, ra});
    rdc(`RPSR_DW_POWER_MGMT_CONTROL_STATUS, 32'h0000_8000, 32'h0000_8000);
    acc(1, `RPSR_DW_ROOTSTS, 4'b0100, 32'h0001_0000);
    rdc(`RPSR_DW_ROOTSTS, 32'hffff_ffff, {15'h0, 1'b1, rb});
    acc(1, `RPSR_DW_ROOTSTS, 4'b0100, 32'h0001_0000);
    rdc(`RPSR_DW_ROOTSTS, 32'hffff_0000, 32'h0000_0000);
    @(negedge mclk_in);
    chk(pme_irq_out, 0);
    wrap_up;
  end
endmodule
`default_nettype wire
